// >>> clp_regs.svh
`ifndef CLP_REGS_SVH
`define CLP_REGS_SVH

// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define CLP_CLK_PERIOD_NS 10
`define CLP_TICK_PERIOD_NS 1000000
`define CLP_TICK_CYCLES (`CLP_TICK_PERIOD_NS / `CLP_CLK_PERIOD_NS)
`define CLP_LR_UNIT_MS 16'h0190
`define CLP_RESTART_MULT 16'h0008
`define CLP_RCV_UNIT_MS 16'h000A
`define CLP_ZC_RUN_GOOD 3'h7

// --------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------
`define CLP_ADDR_CONFIG_6 16'h0106
`define CLP_ADDR_PROT_CTL 16'h01F0
`define CLP_ADDR_SPEED_CFG 16'h01F1
`define CLP_ADDR_RCV_TIME 16'h01F2
`define CLP_ADDR_STEP_TIME 16'h01F3
`define CLP_ADDR_FLAGS_0 16'h0201
`define CLP_ADDR_FLAGS_1 16'h0202
`define CLP_ADDR_FLAGS_2 16'h0203
`define CLP_ADDR_OPEN_STAT 16'h02F0
`define CLP_ADDR_RESET_CMD 16'h0300

// --------------------------------------------------------------------
// Fields, command codes and reset values
// --------------------------------------------------------------------
`define CLP_LR_TIME_HI 6
`define CLP_LR_TIME_LO 3
`define CLP_CTL_OL_EN 0
`define CLP_CTL_ACC_EN 1
`define CLP_CTL_DEC_EN 2
`define CLP_CTL_LR_LATCH 3
`define CLP_CTL_PIN_POL 4
`define CLP_FLAG_LR_BIT 7
`define CLP_FLAG_OL_BIT 4
`define CLP_FLAG_SPD_BIT 3
`define CLP_CMD_LATCH_CLR 8'hFF
`define CLP_CMD_LOGIC_RST 8'h5A
`define CLP_RST_CONFIG_6 7'h00
`define CLP_RST_PROT_CTL 5'h00
`define CLP_RST_SPEED_CFG 7'h04
`define CLP_RST_RCV_TIME 8'h0A
`define CLP_RST_STEP_TIME 8'h0A
`define CLP_PAIR_UV 6'h24
`define CLP_PAIR_VW 6'h09
`define CLP_PAIR_WU 6'h12

`endif

// >>> clp_pkg.sv
package clp_pkg;

  // Protection state, one-hot
  typedef enum logic [3:0] {
    CLP_ST_MONITOR = 4'h1,
    CLP_ST_OPEN_TEST = 4'h2,
    CLP_ST_LR_HOLD = 4'h4,
    CLP_ST_SPD_HOLD = 4'h8
  } clp_state_e;

  typedef logic [15:0] clp_ms_t;
  typedef logic [23:0] clp_cycles_t;

endpackage : clp_pkg

// >>> clp_ms_tick.sv
`timescale 1ns/10ps
`include "clp_regs.svh"

module clp_ms_tick #(
  parameter int unsigned CYCLES = `CLP_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Tick
  output logic tick_out
);

  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // Free running divider, one pulse per period
  always_comb
  begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 17'h00001;
    if (cnt_reg >= 17'(CYCLES - 1))
    begin
      cnt_next = 17'h00000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule : clp_ms_tick

// >>> clp_protect.sv
// Operation
// - Open-load test runs only while open_load_enable is set.
// - After locked rotor, drive UH-VL, VH-WL, WH-UL each up to step time.
// - Open-load flag set when two or more steps miss current limit.
// - A single missing step means all phases connected, no open-load flag.
// - Status shows the single open phase, or all phases when more open.
// - Auto-recovery clears open-load flag after eight locked-rotor times.
// - Latch mode clears open-load flag on enable low, 0% PWM, reset command.
// - Open load is always reported together with the locked-rotor flag.
// - Step time is an upper bound; outputs drop at once on current limit.
// - Accelerating: consecutive early zero crosses equal threshold means abnormal.
// - Decelerating: no zero cross within scaled previous 60-degree period is abnormal.
// - Speed fault turns all gate outputs off and sets accel or decel flag.
// - After recovery time the speed fault clears and restart from free-run.
// - Enable low or logic reset command leaves speed protection early.
// - With its enable clear, speed abnormality is detected but not acted on.
// - Open-loop startup runs for the locked-rotor time in config bits 6:3.
// - Fewer than seven consecutive zero crosses in that time: gates off, flag set.
// - Detection time is 0.4 s times (1 + x); restart time is eight times that.
// - Auto-recovery keeps motor off for eight detection times before retry.
// - Locked-rotor time is measured on a 1 ms tick, one tick of error.
// - Locked-rotor flag is the top bit of the diagnostic register.
// - Fault pin follows any fault, polarity chosen by a config bit.
// - Locked rotor with latch enabled holds outputs off until cleared.
// - Open-load flag is bit 4 of the second diagnostic register.
`timescale 1ns/10ps
`include "clp_regs.svh"

module clp_protect #(
  parameter int unsigned MS_CYCLES = `CLP_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Drive control
  input wire logic en_in,
  input wire logic pwm_zero_in,
  input wire logic startup_active_in,
  input wire logic current_limit_in,
  // Zero-cross logic
  input wire logic zero_cross_in,
  input wire logic zc_window_miss_in,
  input wire logic mask_open_in,
  input wire logic accel_in,
  input wire logic decel_in,
  input wire logic [19:0] period60_in,
  // Register access
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Bridge and status
  output logic gate_off_out,
  output logic [5:0] phase_drive_out,
  output logic restart_req_out,
  output logic speed_event_out,
  output logic locked_rotor_flag_out,
  output logic open_load_flag_out,
  output logic accel_fault_flag_out,
  output logic decel_fault_flag_out,
  output logic fault_indicator_pin_out
);

  // --------------------------------------------------------------------
  // Reset release and common tick
  // --------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic tick;

  // Release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  clp_ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_reg),
    .tick_out(tick)
  );

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // detection time in ms
  function automatic clp_pkg::clp_ms_t clp_lr_ms(input logic [3:0] code);
    clp_pkg::clp_ms_t n;
    n = {12'h000, code} + 16'h0001;
    return 16'(n * `CLP_LR_UNIT_MS);
  endfunction : clp_lr_ms

  // previous period scaled by factor code
  function automatic clp_pkg::clp_cycles_t clp_decel_limit(input logic [19:0] p,
                                                           input logic [2:0] f);
    clp_pkg::clp_cycles_t w;
    clp_pkg::clp_cycles_t r;
    w = {4'h0, p};
    case (f)
      3'h0: r = w + (w >> 2);
      3'h1: r = w + (w >> 1);
      3'h2: r = w + (w >> 1) + (w >> 2);
      3'h3: r = w << 1;
      3'h4: r = (w << 1) + w;
      3'h5: r = w << 2;
      3'h6: r = (w << 2) + (w << 1);
      default: r = w << 3;
    endcase
    return r;
  endfunction : clp_decel_limit

  // map failed pairs to open phases {W,V,U}
  function automatic logic [2:0] clp_open_phase(input logic [2:0] fails);
    logic [2:0] r;
    case (fails)
      3'h3: r = 3'h2;
      3'h6: r = 3'h4;
      3'h5: r = 3'h1;
      3'h7: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : clp_open_phase

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  logic [6:0] cfg6_reg, cfg6_next;
  logic [4:0] ctl_reg, ctl_next;
  logic [6:0] spd_reg, spd_next;
  logic [7:0] rcv_reg, rcv_next;
  logic [7:0] step_reg, step_next;

  always_comb
  begin
    cfg6_next = cfg6_reg;
    ctl_next = ctl_reg;
    spd_next = spd_reg;
    rcv_next = rcv_reg;
    step_next = step_reg;
    if (reg_wr_in && reg_addr_in == `CLP_ADDR_CONFIG_6)
      cfg6_next = reg_wdata_in[6:0];
    else if (reg_wr_in && reg_addr_in == `CLP_ADDR_PROT_CTL)
      ctl_next = reg_wdata_in[4:0];
    else if (reg_wr_in && reg_addr_in == `CLP_ADDR_SPEED_CFG)
      spd_next = reg_wdata_in[6:0];
    else if (reg_wr_in && reg_addr_in == `CLP_ADDR_RCV_TIME)
      rcv_next = reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == `CLP_ADDR_STEP_TIME)
      step_next = reg_wdata_in;
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      cfg6_reg <= `CLP_RST_CONFIG_6;
      ctl_reg <= `CLP_RST_PROT_CTL;
      spd_reg <= `CLP_RST_SPEED_CFG;
      rcv_reg <= `CLP_RST_RCV_TIME;
      step_reg <= `CLP_RST_STEP_TIME;
    end
    else
    begin
      cfg6_reg <= cfg6_next;
      ctl_reg <= ctl_next;
      spd_reg <= spd_next;
      rcv_reg <= rcv_next;
      step_reg <= step_next;
    end
  end

  // --------------------------------------------------------------------
  // Protection sequencer
  // --------------------------------------------------------------------
  clp_pkg::clp_state_e state_reg, state_next;
  clp_pkg::clp_ms_t ms_reg, ms_next;
  clp_pkg::clp_cycles_t since_zc_reg, since_zc_next;
  logic [2:0] zc_run_reg, zc_run_next;
  logic [3:0] acc_cnt_reg, acc_cnt_next;
  logic [1:0] ol_step_reg, ol_step_next;
  logic [2:0] ol_fail_reg, ol_fail_next;
  logic [2:0] open_ph_reg, open_ph_next;
  logic mask_d_reg;
  logic lr_reg, lr_next, ol_reg, ol_next, acc_reg, acc_next, dec_reg, dec_next;
  logic gate_off_reg, gate_off_next, restart_reg, restart_next, event_reg, event_next;
  logic pin_reg, pin_next;
  logic [5:0] drive_reg, drive_next;
  logic [2:0] fails;
  logic early_zc, acc_abn, dec_abn, clr_cmd, logic_rst_cmd, step_done;
  clp_pkg::clp_ms_t lr_ms;

  always_comb
  begin
    state_next = state_reg;
    ms_next = ms_reg;
    since_zc_next = since_zc_reg;
    zc_run_next = zc_run_reg;
    acc_cnt_next = acc_cnt_reg;
    ol_step_next = ol_step_reg;
    ol_fail_next = ol_fail_reg;
    open_ph_next = open_ph_reg;
    lr_next = lr_reg;
    ol_next = ol_reg;
    acc_next = acc_reg;
    dec_next = dec_reg;
    restart_next = 1'b0;
    event_next = 1'b0;
    fails = 3'h0;
    step_done = 1'b0;
    lr_ms = clp_lr_ms(cfg6_reg[`CLP_LR_TIME_HI:`CLP_LR_TIME_LO]);
    clr_cmd = reg_wr_in && reg_addr_in == `CLP_ADDR_RESET_CMD
              && reg_wdata_in == `CLP_CMD_LATCH_CLR;
    logic_rst_cmd = reg_wr_in && reg_addr_in == `CLP_ADDR_RESET_CMD
                    && (reg_wdata_in == `CLP_CMD_LOGIC_RST || reg_wdata_in == `CLP_CMD_LATCH_CLR);
    early_zc = zero_cross_in && mask_d_reg;
    // run of early zero crosses hits threshold
    acc_abn = accel_in && early_zc && (acc_cnt_reg + 4'h1) == spd_reg[3:0];
    // silence longer than scaled 60-degree period
    dec_abn = decel_in && !zero_cross_in
              && since_zc_reg > clp_decel_limit(period60_in, spd_reg[6:4]);
    // enable low drops every protection state and flag
    if (!en_in)
    begin
      state_next = clp_pkg::CLP_ST_MONITOR;
      ms_next = 16'h0000;
      zc_run_next = 3'h0;
      acc_cnt_next = 4'h0;
      since_zc_next = 24'h000000;
      lr_next = 1'b0;
      ol_next = 1'b0;
      acc_next = 1'b0;
      dec_next = 1'b0;
      open_ph_next = 3'h0;
    end
    else
    begin
      case (state_reg)
        clp_pkg::CLP_ST_MONITOR:
        begin
          if (startup_active_in)
          begin
            if (tick)
              ms_next = ms_reg + 16'h0001;
            if (zc_window_miss_in)
              zc_run_next = 3'h0;
            else if (zero_cross_in && zc_run_reg != `CLP_ZC_RUN_GOOD)
              zc_run_next = zc_run_reg + 3'h1;
            // locked rotor: gates off, flag set
            if (zc_run_reg != `CLP_ZC_RUN_GOOD && ms_reg >= lr_ms)
            begin
              lr_next = 1'b1;
              ms_next = 16'h0000;
              ol_step_next = 2'h0;
              ol_fail_next = 3'h0;
              if (ctl_reg[`CLP_CTL_OL_EN])
                state_next = clp_pkg::CLP_ST_OPEN_TEST;
              else
                state_next = clp_pkg::CLP_ST_LR_HOLD;
            end
          end
          else
          begin
            // timer only runs during open-loop startup
            ms_next = 16'h0000;
            zc_run_next = 3'h0;
            if (zero_cross_in)
            begin
              since_zc_next = 24'h000000;
              acc_cnt_next = early_zc ? acc_cnt_reg + 4'h1 : 4'h0;
            end
            else if (since_zc_reg != 24'hFFFFFF)
              since_zc_next = since_zc_reg + 24'h000001;
            // detection always reported, protection only when enabled
            event_next = acc_abn || dec_abn;
            // speed fault: gates off, flag set
            if ((acc_abn && ctl_reg[`CLP_CTL_ACC_EN]) || (dec_abn && ctl_reg[`CLP_CTL_DEC_EN]))
            begin
              acc_next = acc_abn && ctl_reg[`CLP_CTL_ACC_EN];
              dec_next = dec_abn && ctl_reg[`CLP_CTL_DEC_EN];
              ms_next = 16'h0000;
              acc_cnt_next = 4'h0;
              state_next = clp_pkg::CLP_ST_SPD_HOLD;
            end
          end
        end
        clp_pkg::CLP_ST_OPEN_TEST:
        begin
          if (tick)
            ms_next = ms_reg + 16'h0001;
          // current limit ends the step early
          if (current_limit_in)
          begin
            step_done = 1'b1;
            fails = ol_fail_reg;
          end
          else if (ms_reg >= {8'h00, step_reg})
          begin
            step_done = 1'b1;
            fails = ol_fail_reg | (3'h1 << ol_step_reg);
          end
          if (step_done)
          begin
            ms_next = 16'h0000;
            ol_fail_next = fails;
            ol_step_next = ol_step_reg + 2'h1;
            // three pairs in order, then judge
            if (ol_step_reg == 2'h2)
            begin
              state_next = clp_pkg::CLP_ST_LR_HOLD;
              // two or more misses mean open; one miss is ignored
              ol_next = (fails == 3'h3) || (fails == 3'h5) || (fails == 3'h6) || (fails == 3'h7);
              open_ph_next = clp_open_phase(fails);
            end
          end
        end
        clp_pkg::CLP_ST_LR_HOLD:
        begin
          if (tick)
            ms_next = ms_reg + 16'h0001;
          // latch released only by clear events
          if (clr_cmd || pwm_zero_in
              || (!ctl_reg[`CLP_CTL_LR_LATCH] && ms_reg >= 16'(lr_ms * `CLP_RESTART_MULT)))
          begin
            lr_next = 1'b0;
            ol_next = 1'b0;
            open_ph_next = 3'h0;
            ms_next = 16'h0000;
            restart_next = 1'b1;
            state_next = clp_pkg::CLP_ST_MONITOR;
          end
        end
        default:
        begin
          if (tick)
            ms_next = ms_reg + 16'h0001;
          if (logic_rst_cmd || ms_reg >= 16'({8'h00, rcv_reg} * `CLP_RCV_UNIT_MS))
          begin
            acc_next = 1'b0;
            dec_next = 1'b0;
            ms_next = 16'h0000;
            since_zc_next = 24'h000000;
            restart_next = 1'b1;
            state_next = clp_pkg::CLP_ST_MONITOR;
          end
        end
      endcase
    end
    gate_off_next = state_next != clp_pkg::CLP_ST_MONITOR;
    drive_next = 6'h00;
    if (state_next == clp_pkg::CLP_ST_OPEN_TEST && !current_limit_in)
      drive_next = (ol_step_next == 2'h0) ? `CLP_PAIR_UV :
                   (ol_step_next == 2'h1) ? `CLP_PAIR_VW : `CLP_PAIR_WU;
    pin_next = (lr_next || ol_next || acc_next || dec_next) ^ ctl_reg[`CLP_CTL_PIN_POL];
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      state_reg <= clp_pkg::CLP_ST_MONITOR;
      ms_reg <= 16'h0000;
      since_zc_reg <= 24'h000000;
      zc_run_reg <= 3'h0;
      acc_cnt_reg <= 4'h0;
      ol_step_reg <= 2'h0;
      ol_fail_reg <= 3'h0;
      open_ph_reg <= 3'h0;
      mask_d_reg <= 1'b0;
      lr_reg <= 1'b0;
      ol_reg <= 1'b0;
      acc_reg <= 1'b0;
      dec_reg <= 1'b0;
      gate_off_reg <= 1'b0;
      restart_reg <= 1'b0;
      event_reg <= 1'b0;
      pin_reg <= 1'b0;
      drive_reg <= 6'h00;
    end
    else
    begin
      state_reg <= state_next;
      ms_reg <= ms_next;
      since_zc_reg <= since_zc_next;
      zc_run_reg <= zc_run_next;
      acc_cnt_reg <= acc_cnt_next;
      ol_step_reg <= ol_step_next;
      ol_fail_reg <= ol_fail_next;
      open_ph_reg <= open_ph_next;
      mask_d_reg <= mask_open_in;
      lr_reg <= lr_next;
      ol_reg <= ol_next;
      acc_reg <= acc_next;
      dec_reg <= dec_next;
      gate_off_reg <= gate_off_next;
      restart_reg <= restart_next;
      event_reg <= event_next;
      pin_reg <= pin_next;
      drive_reg <= drive_next;
    end
  end

  // --------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------
  logic [7:0] rdata_reg, rdata_next;

  // One cycle read latency; unmapped and write-only offsets read zero
  always_comb
  begin
    rdata_next = 8'h00;
    if (reg_addr_in == `CLP_ADDR_CONFIG_6)
      rdata_next = {1'b0, cfg6_reg};
    else if (reg_addr_in == `CLP_ADDR_PROT_CTL)
      rdata_next = {3'h0, ctl_reg};
    else if (reg_addr_in == `CLP_ADDR_SPEED_CFG)
      rdata_next = {1'b0, spd_reg};
    else if (reg_addr_in == `CLP_ADDR_RCV_TIME)
      rdata_next = rcv_reg;
    else if (reg_addr_in == `CLP_ADDR_STEP_TIME)
      rdata_next = step_reg;
    else if (reg_addr_in == `CLP_ADDR_FLAGS_0)
      rdata_next = 8'(lr_reg) << `CLP_FLAG_LR_BIT;
    else if (reg_addr_in == `CLP_ADDR_FLAGS_1)
      rdata_next = 8'(ol_reg) << `CLP_FLAG_OL_BIT;
    else if (reg_addr_in == `CLP_ADDR_FLAGS_2)
      rdata_next = 8'(acc_reg | dec_reg) << `CLP_FLAG_SPD_BIT;
    else if (reg_addr_in == `CLP_ADDR_OPEN_STAT)
      rdata_next = {2'h0, dec_reg, acc_reg, 1'b0, open_ph_reg};
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // Outputs straight from flops; open load only ever with locked rotor
  assign reg_rdata_out = rdata_reg;
  assign gate_off_out = gate_off_reg;
  assign phase_drive_out = drive_reg;
  assign restart_req_out = restart_reg;
  assign speed_event_out = event_reg;
  assign locked_rotor_flag_out = lr_reg;
  assign open_load_flag_out = ol_reg;
  assign accel_fault_flag_out = acc_reg;
  assign decel_fault_flag_out = dec_reg;
  assign fault_indicator_pin_out = pin_reg;

endmodule : clp_protect

// >>> clp_protect_chk.sv
`timescale 1ns/10ps
module clp_protect_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Watched inputs
  input wire logic en_in,
  input wire logic current_limit_in,
  input wire logic [15:0] reg_addr_in,
  // Watched outputs
  input wire logic [7:0] reg_rdata_out,
  input wire logic [5:0] phase_drive_out,
  input wire logic gate_off_out,
  input wire logic restart_req_out,
  input wire logic locked_rotor_flag_out,
  input wire logic open_load_flag_out,
  input wire logic accel_fault_flag_out,
  input wire logic decel_fault_flag_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_ol_with_lr:
    assert property (open_load_flag_out |-> locked_rotor_flag_out) else $error("open load alone");
  a_drive_pairs_only:
    assert property (phase_drive_out inside {6'h00, 6'h24, 6'h09, 6'h12}) else $error("bad pair");
  a_limit_ends_step:
    assert property (phase_drive_out != 6'h00 && current_limit_in
      |=> phase_drive_out != $past(phase_drive_out)) else $error("step ran past limit");
  a_speed_gate_off:
    assert property ($rose(accel_fault_flag_out) || $rose(decel_fault_flag_out) |-> gate_off_out)
      else $error("gates on in speed fault");
  a_en_low_clears:
    assert property (!en_in |=> !(locked_rotor_flag_out || open_load_flag_out
      || accel_fault_flag_out || decel_fault_flag_out)) else $error("flag kept with en low");
  a_restart_pulse:
    assert property (restart_req_out |=> !restart_req_out) else $error("restart too long");
  a_read_lr_bit:
    assert property (reg_addr_in == 16'h0201 |=> reg_rdata_out[7] == $past(locked_rotor_flag_out))
      else $error("lr bit wrong");
  a_read_ol_bit:
    assert property (reg_addr_in == 16'h0202 |=> reg_rdata_out[4] == $past(open_load_flag_out))
      else $error("ol bit wrong");
  // Main scenarios reached
  c_open_load: cover property ($rose(open_load_flag_out));
  c_accel: cover property ($rose(accel_fault_flag_out));
  c_restart: cover property (restart_req_out);
endmodule : clp_protect_chk

bind clp_protect clp_protect_chk chk (.clk_in, .rst_n_in, .en_in, .current_limit_in,
  .reg_addr_in, .reg_rdata_out, .phase_drive_out, .gate_off_out, .restart_req_out,
  .locked_rotor_flag_out, .open_load_flag_out, .accel_fault_flag_out, .decel_fault_flag_out);

// >>> clp_bridge_model.sv
`timescale 1ns/10ps
module clp_bridge_model #(
  parameter int DELAY = 3
) (
  // Clock
  input wire logic clk_in,
  // Drive and broken windings
  input wire logic [5:0] drive_in,
  input wire logic [2:0] fail_pairs_in,
  // Current sense
  output logic current_limit_out
);
  logic [5:0] prev_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic ok;
  // Current builds only while one closed pair stays driven
  always_comb
  begin
    cnt_next = (drive_in != prev_reg) ? 8'h00 : cnt_reg + {7'h00, cnt_reg != 8'hFF};
    ok = (drive_in == 6'h24 && !fail_pairs_in[0]) || (drive_in == 6'h09 && !fail_pairs_in[1])
      || (drive_in == 6'h12 && !fail_pairs_in[2]);
    current_limit_out = ok && drive_in == prev_reg && cnt_reg >= DELAY;
  end
  // Rise time counter
  always_ff @(posedge clk_in)
  begin
    prev_reg <= drive_in;
    cnt_reg <= cnt_next;
  end
endmodule : clp_bridge_model

// >>> clp_protect_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module clp_protect_tb_top;
  logic clk_in, rst_n_in, en_in, pwm_zero_in, startup_active_in, current_limit_in;
  logic zero_cross_in, zc_window_miss_in, mask_open_in, accel_in, decel_in, reg_wr_in;
  logic [19:0] period60_in;
  logic [15:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, d;
  logic [5:0] phase_drive_out, last;
  logic [17:0] seq;
  logic [2:0] fail_pairs;
  logic gate_off_out, restart_req_out, speed_event_out, lr_flag, ol_flag, acc_flag, dec_flag;
  logic pin;
  int n_errors = 0;
  int n_tests = 0;
  int i;
  time t0;
  clp_protect #(.MS_CYCLES(10)) dut (.clk_in, .rst_n_in, .en_in, .pwm_zero_in,
    .startup_active_in, .current_limit_in, .zero_cross_in, .zc_window_miss_in, .mask_open_in,
    .accel_in, .decel_in, .period60_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
    .gate_off_out, .phase_drive_out, .restart_req_out, .speed_event_out,
    .locked_rotor_flag_out(lr_flag), .open_load_flag_out(ol_flag), .accel_fault_flag_out(acc_flag),
    .decel_fault_flag_out(dec_flag), .fault_indicator_pin_out(pin));
  clp_bridge_model #(.DELAY(3)) bridge (.clk_in, .drive_in(phase_drive_out),
    .fail_pairs_in(fail_pairs), .current_limit_out(current_limit_in));
  // 100 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  task wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    step(1);
    reg_wr_in = 1'b0;
    // Idle edge so a following write never re-raises the strobe in this step
    step(1);
  endtask : wr
  task rd(input logic [15:0] a);
    reg_addr_in = a;
    step(1);
    d = reg_rdata_out;
  endtask : rd
  task t_regs;
    rd(16'h0106);
    `CHK("config6 reset", 8'h00, d)
    wr(16'h0106, 8'hFF);
    rd(16'h0106);
    `CHK("config6 rw", 8'h7F, d)
    rd(16'h01F1);
    `CHK("speed cfg reset", 8'h04, d)
    rd(16'h0000);
    `CHK("unmapped", 8'h00, d)
    wr(16'h0106, 8'h00);
  endtask : t_regs
  task t_open_load;
    wr(16'h01F0, 8'h01);
    wr(16'h01F3, 8'h02);
    fail_pairs = 3'b011;
    startup_active_in = 1'b1;
    for (i = 0; i < 4100 && lr_flag !== 1'b1; i++) step(1);
    `CHK("lr time", 1'b1, i >= 3985 && i <= 4030)
    startup_active_in = 1'b0;
    t0 = $time;
    last = 6'h00;
    for (i = 0; i < 200; i++)
    begin
      if (phase_drive_out != 6'h00 && phase_drive_out !== last)
      begin
        seq = {seq[11:0], phase_drive_out};
        last = phase_drive_out;
      end
      step(1);
    end
    `CHK("pair order", {6'h24, 6'h09, 6'h12}, seq)
    `CHK("ol flag", 1'b1, ol_flag)
    rd(16'h0201);
    `CHK("lr bit", 1'b1, d[7])
    rd(16'h0202);
    `CHK("ol bit", 1'b1, d[4])
    rd(16'h02F0);
    `CHK("open phase", 3'b010, d[2:0])
    for (i = 0; i < 33000 && lr_flag === 1'b1; i++) step(1);
    `CHK("hold time", 1'b1, ($time - t0) / 10 >= 31990 && ($time - t0) / 10 <= 32200)
    `CHK("ol cleared", 1'b0, ol_flag)
  endtask : t_open_load
  task t_latch;
    wr(16'h01F0, 8'h09);
    fail_pairs = 3'b001;
    startup_active_in = 1'b1;
    for (i = 0; i < 4100 && lr_flag !== 1'b1; i++) step(1);
    startup_active_in = 1'b0;
    step(32300);
    `CHK("one pair open", 1'b0, ol_flag)
    `CHK("latched", 1'b1, lr_flag)
    pwm_zero_in = 1'b1;
    step(2);
    pwm_zero_in = 1'b0;
    `CHK("pwm zero clear", 1'b0, lr_flag)
  endtask : t_latch
  task t_decel;
    wr(16'h01F0, 8'h00);
    wr(16'h01F1, 8'h03);
    wr(16'h01F2, 8'h01);
    period60_in = 20'd16;
    decel_in = 1'b1;
    zero_cross_in = 1'b1;
    step(1);
    zero_cross_in = 1'b0;
    step(17);
    `CHK("decel early", 1'b0, dec_flag)
    `CHK("event early", 1'b0, speed_event_out)
    step(5);
    `CHK("event late", 1'b1, speed_event_out)
    `CHK("disabled no flag", 1'b0, dec_flag)
    // Protection armed while the silence persists
    wr(16'h01F0, 8'h04);
    `CHK("decel late", 1'b1, dec_flag)
    `CHK("fault pin", 1'b1, pin)
    decel_in = 1'b0;
    t0 = $time;
    for (i = 0; i < 200 && dec_flag === 1'b1; i++) step(1);
    `CHK("decel recover", 1'b1, ($time - t0) / 10 >= 90 && ($time - t0) / 10 <= 108)
  endtask : t_decel
  task t_accel;
    wr(16'h01F0, 8'h02);
    wr(16'h01F1, 8'h43);
    accel_in = 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        mask_open_in = 1'b1;
        step(1);
        mask_open_in = 1'b0;
        zero_cross_in = 1'b1;
        step(1);
        zero_cross_in = 1'b0;
        step(3);
        `CHK("accel count", k == 2, acc_flag)
      end
      `CHK("accel gates", 1'b1, gate_off_out)
      if (r == 0) wr(16'h0300, 8'h5A);
      else en_in = 1'b0;
      step(2);
      en_in = 1'b1;
      `CHK("accel cleared", 1'b0, acc_flag)
    end
    accel_in = 1'b0;
  endtask : t_accel
  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the expected run
  initial
  begin
    #1000000;
    n_errors++;
    tally_and_finish;
  end
  // Main sequence
  initial
  begin
    {rst_n_in, pwm_zero_in, startup_active_in, zero_cross_in, zc_window_miss_in} = 5'h00;
    {mask_open_in, accel_in, decel_in, reg_wr_in} = 4'h0;
    {en_in, period60_in, reg_addr_in, reg_wdata_in, fail_pairs, seq} = 0;
    en_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    step(3);
    t_regs;
    t_open_load;
    t_latch;
    t_decel;
    t_accel;
    tally_and_finish;
  end
endmodule : clp_protect_tb_top
